// ### hw/sarc_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sarc_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // conversion triggers
  input  wire logic        external_convert_start_pin,
  input  wire logic        timer_zero_trigger,
  input  wire logic        timer_one_trigger,
  input  wire logic        programmable_logic_array_trigger,
  // comparator from the capacitive dacs
  input  wire logic        comparator_in,
  // analog front end control
  output logic             power_enable,
  output logic             sample_switch_closed,
  output logic      [1:0]  conversion_mode,
  output logic      [4:0]  positive_select,
  output logic      [4:0]  negative_select,
  output logic             negative_input_connect,
  output logic      [5:0]  gain_code_channel_zero,
  output logic      [5:0]  gain_code_channel_one,
  output logic             buffer_bypass_pos,
  output logic             buffer_bypass_neg,
  output logic      [11:0] sar_dac_code,
  // status
  output logic             converter_busy,
  output logic             conversion_done
);

  logic [15:0] ctrl_q;
  logic [4:0]  pos_q;
  logic [4:0]  neg_q;
  logic        status_q;
  logic [11:0] result_q;
  logic [11:0] gain_q;
  logic [31:0] prdata_q;
  logic        single_pend_q;
  logic [7:0]  pwr_cnt_q;
  logic [2:0]  pin_sync_q;
  logic        pin_level_q;
  logic        pin_level_d;
  logic        pin_rise;
  sarc_pkg::sarc_state_t state_q;
  logic [6:0]  acq_cnt_q;
  logic [4:0]  bit_cnt_q;
  logic [11:0] sar_q;
  logic [11:0] trial_q;
  logic        tick;

  logic        acc;
  logic        wr;
  logic        wr_ctrl;
  logic        rd_dat;
  logic        soft_rst;
  logic        hit;
  logic [2:0]  trig;
  logic [1:0]  mode;
  logic        pwr_ready;
  logic        trig_event;
  logic        start;
  logic        done;
  logic        abort;
  logic [6:0]  acq_len;

  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign wr_ctrl  = wr && (paddr == sarc_pkg::ADDR_CTRL);
  assign rd_dat   = acc && !pwrite && (paddr == sarc_pkg::ADDR_DAT);
  assign soft_rst = wr && (paddr == sarc_pkg::ADDR_RST) && pwdata[0];
  assign hit      = (paddr == sarc_pkg::ADDR_CTRL) || (paddr == sarc_pkg::ADDR_POS) ||
                    (paddr == sarc_pkg::ADDR_NEG)  || (paddr == sarc_pkg::ADDR_STA) ||
                    (paddr == sarc_pkg::ADDR_DAT)  || (paddr == sarc_pkg::ADDR_RST) ||
                    (paddr == sarc_pkg::ADDR_GAIN);

  // zero wait states; read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = prdata_q;

  assign trig = ctrl_q[sarc_pkg::CTRL_TRIG_LSB +: 3];
  assign mode = ctrl_q[sarc_pkg::CTRL_MODE_LSB +: 2];

  // control register; bit six is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sarc_pkg::CTRL_RESET;
    end else if (soft_rst) begin
      ctrl_q <= sarc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[15:0] & sarc_pkg::CTRL_WR_MASK;
    end else if (done && trig == sarc_pkg::TRIG_SINGLE) begin
      ctrl_q[sarc_pkg::CTRL_TRIG_LSB +: 3] <= sarc_pkg::TRIG_PIN;
    end
  end

  // channel and gain registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q  <= sarc_pkg::SEL_RESET[4:0];
      neg_q  <= sarc_pkg::SEL_RESET[4:0];
      gain_q <= sarc_pkg::GAIN_RESET;
    end else if (soft_rst) begin
      pos_q  <= sarc_pkg::SEL_RESET[4:0];
      neg_q  <= sarc_pkg::SEL_RESET[4:0];
      gain_q <= sarc_pkg::GAIN_RESET;
    end else if (wr) begin
      if (paddr == sarc_pkg::ADDR_POS) begin
        pos_q <= pwdata[4:0];
      end
      if (paddr == sarc_pkg::ADDR_NEG) begin
        neg_q <= pwdata[4:0];
      end
      if (paddr == sarc_pkg::ADDR_GAIN) begin
        gain_q <= pwdata[11:0];
      end
    end
  end

  // status: a completion in the same cycle as a result read wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 1'b0;
    end else if (done) begin
      status_q <= 1'b1;
    end else if (soft_rst || rd_dat) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= sarc_pkg::RESULT_RESET;
    end else if (done) begin
      result_q <= sar_q;
    end else if (soft_rst) begin
      result_q <= sarc_pkg::RESULT_RESET;
    end
  end

  // read mux, captured when the setup cycle is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        sarc_pkg::ADDR_CTRL: prdata_q <= {16'h0000, ctrl_q};
        sarc_pkg::ADDR_POS:  prdata_q <= {27'h000_0000, pos_q};
        sarc_pkg::ADDR_NEG:  prdata_q <= {27'h000_0000, neg_q};
        sarc_pkg::ADDR_STA:  prdata_q <= {31'h0000_0000, status_q};
        sarc_pkg::ADDR_DAT:  prdata_q <= {4'h0, result_q, 16'h0000};
        sarc_pkg::ADDR_GAIN: prdata_q <= {20'h0_0000, gain_q};
        default:             prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // settling time after power-up before any start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cnt_q <= 8'h00;
    end else if (!ctrl_q[sarc_pkg::CTRL_PWR_BIT]) begin
      pwr_cnt_q <= 8'h00;
    end else if (!pwr_ready) begin
      pwr_cnt_q <= pwr_cnt_q + 8'h01;
    end
  end
  assign pwr_ready = (pwr_cnt_q == 8'(sarc_pkg::PWRUP_CYCLES));

  // external pin: three stages, a level counts once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_q  <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q  <= {pin_sync_q[1:0], external_convert_start_pin};
      pin_level_q <= pin_level_d;
    end
  end
  assign pin_level_d = (pin_sync_q[2] == pin_sync_q[1]) ? pin_sync_q[2] : pin_level_q;
  assign pin_rise    = pin_level_d && !pin_level_q;

  // single software start survives until the sequencer takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_pend_q <= 1'b0;
    end else if (soft_rst) begin
      single_pend_q <= 1'b0;
    end else if (wr_ctrl) begin
      single_pend_q <= (pwdata[sarc_pkg::CTRL_TRIG_LSB +: 3] == sarc_pkg::TRIG_SINGLE);
    end else if (start) begin
      single_pend_q <= 1'b0;
    end
  end

  always_comb begin
    case (trig)
      sarc_pkg::TRIG_PIN:    trig_event = pin_rise;
      sarc_pkg::TRIG_TIMER_ONE_TRIGGER: trig_event = timer_one_trigger;
      sarc_pkg::TRIG_TIMER_ZERO_TRIGGER: trig_event = timer_zero_trigger;
      sarc_pkg::TRIG_SINGLE: trig_event = single_pend_q;
      sarc_pkg::TRIG_CONT:   trig_event = 1'b1;
      sarc_pkg::TRIG_PLA:    trig_event = programmable_logic_array_trigger;
      default:               trig_event = 1'b0;
    endcase
  end

  assign start = (state_q == sarc_pkg::ST_IDLE) && trig_event && pwr_ready && !soft_rst &&
                 ctrl_q[sarc_pkg::CTRL_EN_BIT] &&
                 (mode != 2'b11);
  assign abort = soft_rst || !ctrl_q[sarc_pkg::CTRL_PWR_BIT];
  assign done  = (state_q == sarc_pkg::ST_CONV) && tick && !abort &&
                 (bit_cnt_q == 5'(sarc_pkg::CONV_CLOCKS - 1));

  always_comb begin
    case (sarc_pkg::code_clamp(ctrl_q[sarc_pkg::CTRL_ACQ_LSB +: 3]))
      3'h0:    acq_len = 7'h02;
      3'h1:    acq_len = 7'h04;
      3'h2:    acq_len = 7'h08;
      3'h3:    acq_len = 7'h10;
      3'h4:    acq_len = 7'h20;
      default: acq_len = 7'h40;
    endcase
  end

  sarc_clkdiv u_clkdiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .div_code (ctrl_q[sarc_pkg::CTRL_DIV_LSB +: 3]),
    .restart  (start),
    .tick     (tick)
  );

  // sequencer: acquisition, then 19 converter clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= sarc_pkg::ST_IDLE;
      acq_cnt_q <= 7'h00;
      bit_cnt_q <= 5'h00;
    end else if (abort) begin
      state_q <= sarc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sarc_pkg::ST_IDLE: begin
          if (start) begin
            state_q   <= sarc_pkg::ST_ACQ;
            acq_cnt_q <= 7'h00;
          end
        end
        sarc_pkg::ST_ACQ: begin
          if (tick) begin
            if (acq_cnt_q == acq_len - 7'h01) begin
              state_q   <= sarc_pkg::ST_CONV;
              bit_cnt_q <= 5'h00;
            end else begin
              acq_cnt_q <= acq_cnt_q + 7'h01;
            end
          end
        end
        sarc_pkg::ST_CONV: begin
          if (tick) begin
            if (done) begin
              state_q <= sarc_pkg::ST_IDLE;
            end else begin
              bit_cnt_q <= bit_cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= sarc_pkg::ST_IDLE;
      endcase
    end
  end

  // binary search: keep the trial bit while the comparator says input is above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q   <= 12'h000;
      trial_q <= 12'h000;
    end else if (state_q == sarc_pkg::ST_ACQ) begin
      sar_q   <= 12'h800;
      trial_q <= 12'h800;
    end else if (state_q == sarc_pkg::ST_CONV && tick && trial_q != 12'h000) begin
      sar_q   <= (sar_q & ~trial_q) | (comparator_in ? trial_q : 12'h000) | (trial_q >> 1);
      trial_q <= trial_q >> 1;
    end
  end

  assign power_enable           = ctrl_q[sarc_pkg::CTRL_PWR_BIT];
  assign sample_switch_closed   = (state_q != sarc_pkg::ST_CONV);
  assign conversion_mode        = mode;
  assign positive_select        = pos_q;
  assign negative_select        = neg_q;
  // single-ended ties the negative side to ground inside the front end
  assign negative_input_connect = (mode == sarc_pkg::MODE_DIFF) ||
                                  (mode == sarc_pkg::MODE_PSEUDO);
  assign gain_code_channel_zero = gain_q[sarc_pkg::GAIN0_LSB +: 6];
  assign gain_code_channel_one  = gain_q[sarc_pkg::GAIN1_LSB +: 6];
  assign buffer_bypass_pos      = ctrl_q[sarc_pkg::CTRL_BYPP_BIT];
  assign buffer_bypass_neg      = ctrl_q[sarc_pkg::CTRL_BYPN_BIT];
  assign sar_dac_code           = sar_q;
  assign converter_busy         = (state_q != sarc_pkg::ST_IDLE);
  assign conversion_done        = done;

  a_enable_gates_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == sarc_pkg::ST_IDLE && !ctrl_q[sarc_pkg::CTRL_EN_BIT]) |=> !converter_busy)
    else $error("conversion started while disabled");

  a_powerup_holdoff: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(power_enable) |=> !converter_busy [*8])
    else $error("conversion started inside power-up time");

  a_single_returns: assert property (@(posedge pclk) disable iff (!presetn)
    (done && trig == sarc_pkg::TRIG_SINGLE && !wr_ctrl && !soft_rst) |=>
    (trig == sarc_pkg::TRIG_PIN))
    else $error("single conversion code not returned");

  a_done_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    conversion_done |=> (status_q && result_q == $past(sar_q)))
    else $error("completion did not set flag and result");

  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_dat && !done) |=> !status_q)
    else $error("result read did not clear flag");

  a_result_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == sarc_pkg::ADDR_DAT) |=>
    (prdata == {4'h0, $past(result_q), 16'h0000}))
    else $error("result not in bits 27 to 16");

  a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst |=> (ctrl_q == sarc_pkg::CTRL_RESET && !status_q && pos_q == 5'h00 &&
    gain_q == 12'h000 && !converter_busy))
    else $error("soft reset left a register set");

  // checks the acquisition exit itself, not just the output decode
  a_switch_open: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == sarc_pkg::ST_ACQ && tick && !abort && acq_cnt_q == acq_len - 7'h01) |=>
    (!sample_switch_closed && converter_busy))
    else $error("switches closed during conversion");

  a_busy_falls: assert property (@(posedge pclk) disable iff (!presetn)
    conversion_done |-> converter_busy ##1 !converter_busy)
    else $error("busy did not fall at completion");

  a_reserved_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == sarc_pkg::ST_IDLE && mode == 2'b11) |=> !converter_busy)
    else $error("conversion started in reserved mode");

endmodule
`default_nettype wire

// ### hw/sarc_pkg.sv
// Summary of operation
// - enable bit gates every conversion start
// - power bit on; starts held for 5 us
// - mode field: single, differential, pseudo differential
// - trigger field selects pin, timers, continuous, logic
// - single software start, field returns to 000
// - positive mux five-bit field, upper bits zero
// - negative mux five-bit field, upper bits zero
// - completion sets status bit zero
// - reading result clears status bit
// - result sits in bits 27 to 16
// - reset register bit zero restores all defaults
// - gain register holds two six-bit codes
// - conversion start opens the sampling switches; the code opens them only once acquisition ends
// - complete once comparator rebalanced, code produced
// - differential mode uses both multiplexers
// - conversion is acquisition plus 19 converter clocks
// - divider field divides core clock by powers of two
// - acquisition field sets 2 to 64 clocks
// - busy high during conversion; done pulse raised
package sarc_pkg;

  localparam logic [31:0] ADDR_CTRL = 32'hffff_0500;
  localparam logic [31:0] ADDR_POS  = 32'hffff_0504;
  localparam logic [31:0] ADDR_NEG  = 32'hffff_0508;
  localparam logic [31:0] ADDR_STA  = 32'hffff_050c;
  localparam logic [31:0] ADDR_DAT  = 32'hffff_0510;
  localparam logic [31:0] ADDR_RST  = 32'hffff_0514;
  localparam logic [31:0] ADDR_GAIN = 32'hffff_0520;

  localparam logic [15:0] CTRL_RESET   = 16'h0a00;
  localparam logic [15:0] CTRL_WR_MASK = 16'hffbf;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [11:0] GAIN_RESET   = 12'h000;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_PWR_BIT  = 5;
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_ACQ_LSB  = 8;
  localparam int CTRL_DIV_LSB  = 11;
  localparam int CTRL_BYPN_BIT = 14;
  localparam int CTRL_BYPP_BIT = 15;
  localparam int RESULT_LSB    = 16;
  localparam int GAIN0_LSB     = 6;
  localparam int GAIN1_LSB     = 0;

  localparam int RES_BITS    = 12;
  localparam int CONV_CLOCKS = 19;

  localparam int CLK_PERIOD_NS  = 25;
  localparam int PWRUP_TIME_US  = 5;
  localparam int PWRUP_CYCLES   = (PWRUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    TRIG_PIN    = 3'b000,
    TRIG_TIMER_ONE_TRIGGER = 3'b001,
    TRIG_TIMER_ZERO_TRIGGER = 3'b010,
    TRIG_SINGLE = 3'b011,
    TRIG_CONT   = 3'b100,
    TRIG_PLA    = 3'b101
  } sarc_trig_t;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DIFF   = 2'b01,
    MODE_PSEUDO = 2'b10
  } sarc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10
  } sarc_state_t;

  // codes above 101 clamp to the slowest setting
  function automatic logic [2:0] code_clamp(input logic [2:0] code);
    code_clamp = (code > 3'h5) ? 3'h5 : code;
  endfunction

endpackage

// ### hw/sarc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_clkdiv (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic [2:0] div_code,
  input  wire logic       restart,
  // converter clock enable
  output logic            tick
);

  logic [4:0] cnt_q;
  logic [4:0] limit;

  // divide by 1, 2, 4, 8, 16, 32
  assign limit = 5'((6'h01 << sarc_pkg::code_clamp(div_code)) - 6'h01);
  assign tick  = !restart && (cnt_q >= limit);

  // restart aligns converter clocks to the start of a conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
    end else if (restart || tick) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

endmodule
`default_nettype wire

// ### verification/sarc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_top_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  trig;
  logic        comparator_in;
  logic        power_enable;
  logic        sample_switch_closed;
  logic [1:0]  conversion_mode;
  logic [4:0]  positive_select;
  logic [4:0]  negative_select;
  logic        negative_input_connect;
  logic [5:0]  gain_code_channel_zero;
  logic [5:0]  gain_code_channel_one;
  logic        buffer_bypass_pos;
  logic        buffer_bypass_neg;
  logic [11:0] sar_dac_code;
  logic        converter_busy;
  logic        conversion_done;
  logic        busy_q = 1'b0;
  logic        opened = 1'b0;
  logic [31:0] q;
  logic        e;
  int          busy_n = 0;
  int          starts = 0;
  int          fails = 0;
  int          n_compared = 0;

  // trig bits: pin, timer one, timer zero, logic array
  sarc_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_convert_start_pin(trig[0]),
    .timer_one_trigger(trig[1]),
    .timer_zero_trigger(trig[2]),
    .programmable_logic_array_trigger(trig[3]),
    .comparator_in, .power_enable, .sample_switch_closed, .conversion_mode,
    .positive_select, .negative_select, .negative_input_connect,
    .gain_code_channel_zero, .gain_code_channel_one, .buffer_bypass_pos,
    .buffer_bypass_neg, .sar_dac_code, .converter_busy, .conversion_done
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // busy length and start count, measured from the pins alone
  always @(posedge pclk) begin
    if (converter_busy === 1'b1) begin
      busy_n <= busy_q ? busy_n + 1 : 1;
      if (!busy_q) starts <= starts + 1;
      if (sample_switch_closed === 1'b0) opened <= 1'b1;
    end
    busy_q <= (converter_busy === 1'b1);
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask

  // the master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready wait", 32'(k < 100), 32'h0000_0001);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    check($sformatf("read %h", a), q, exp);
    check($sformatf("pslverr %h", a), {31'b0, e}, {31'b0, err});
  endtask

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (conversion_done !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
    check("done wait", 32'(k < lim), 32'h0000_0001);
    repeat (2) @(posedge pclk);
  endtask

  logic [31:0] raddr [6];
  logic [2:0]  code [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  logic [1:0]  md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [31:0] bad [4] = '{32'h0000_0024, 32'h0000_00bc, 32'h0000_00a6, 32'h0000_00a7};
  int          dv [4] = '{0, 1, 2, 5};
  int          aq [4] = '{0, 2, 5, 1};

  initial begin
    int s0;
    int ex;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    trig = 4'h0;
    comparator_in = 1'b1;
    raddr = '{sarc_pkg::ADDR_POS, sarc_pkg::ADDR_NEG, sarc_pkg::ADDR_STA,
              sarc_pkg::ADDR_DAT, sarc_pkg::ADDR_RST, sarc_pkg::ADDR_GAIN};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(sarc_pkg::ADDR_CTRL, 32'h0000_0a00, 1'b0);
    foreach (raddr[i]) rd_chk(raddr[i], 32'h0000_0000, 1'b0);
    rd_chk(32'hffff_0518, 32'h0000_0000, 1'b1);
    // single start written while powered down must wait out the power-up time
    wr(sarc_pkg::ADDR_CTRL, 32'h0000_00a3);
    repeat (150) @(posedge pclk);
    check("early start", 32'(starts), 32'h0000_0000);
    check("power pin", {31'b0, power_enable}, 32'h0000_0001);
    wait_done(400);
    check("switch open", {31'b0, opened}, 32'h0000_0001);
    check("dac code", {20'b0, sar_dac_code}, 32'h0000_0fff);
    check("busy after", {31'b0, converter_busy}, 32'h0000_0000);
    rd_chk(sarc_pkg::ADDR_STA, 32'h0000_0001, 1'b0);
    rd_chk(sarc_pkg::ADDR_DAT, 32'h0fff_0000, 1'b0);
    rd_chk(sarc_pkg::ADDR_STA, 32'h0000_0000, 1'b0);
    rd_chk(sarc_pkg::ADDR_CTRL, 32'h0000_00a0, 1'b0);
    // disabled, reserved mode and reserved trigger codes, all triggers toggling
    foreach (bad[i]) begin
      s0 = starts;
      wr(sarc_pkg::ADDR_CTRL, bad[i]);
      trig <= 4'hf;
      repeat (60) @(posedge pclk);
      trig <= 4'h0;
      repeat (10) @(posedge pclk);
      check("no start", 32'(starts - s0), 32'h0000_0000);
    end
    foreach (code[i]) begin
      comparator_in <= i[0];
      wr(sarc_pkg::ADDR_CTRL, 32'h0000_00a0 | 32'(md[i]) << 3 | 32'(code[i]));
      repeat (5) @(posedge pclk);
      check("mode pin", {30'b0, conversion_mode}, 32'(md[i]));
      check("neg connect", {31'b0, negative_input_connect}, 32'(md[i] != 2'h0));
      trig <= 4'h1 << i;
      repeat (4) @(posedge pclk);
      trig <= 4'h0;
      wait_done(400);
      rd_chk(sarc_pkg::ADDR_DAT, i[0] ? 32'h0fff_0000 : 32'h0000_0000, 1'b0);
    end
    s0 = starts;
    wr(sarc_pkg::ADDR_CTRL, 32'h0000_00a4);
    wait_done(400);
    wait_done(400);
    wr(sarc_pkg::ADDR_CTRL, 32'h0000_0020);
    repeat (200) @(posedge pclk);
    check("continuous", 32'(starts - s0 >= 2), 32'h0000_0001);
    // divider and acquisition codes against the measured busy time
    foreach (dv[i]) begin
      wr(sarc_pkg::ADDR_CTRL, 32'h0000_00a3 | 32'(dv[i]) << 11 | 32'(aq[i]) << 8);
      wait_done(3000);
      ex = ((2 << aq[i]) + 19) * (1 << dv[i]);
      check("busy length", 32'(busy_n >= ex - 1 && busy_n <= ex + (1 << dv[i]) + 2),
            32'h0000_0001);
    end
    apb(1'b0, sarc_pkg::ADDR_DAT, 32'h0000_0000);
    wr(sarc_pkg::ADDR_POS, 32'h0000_00ed);
    wr(sarc_pkg::ADDR_NEG, 32'h0000_0010);
    wr(sarc_pkg::ADDR_GAIN, 32'h0000_0811);
    wr(sarc_pkg::ADDR_CTRL, 32'h0000_c020);
    wr(sarc_pkg::ADDR_STA, 32'h0000_0001);
    wr(sarc_pkg::ADDR_DAT, 32'hffff_ffff);
    check("pos pin", {27'b0, positive_select}, 32'h0000_000d);
    check("neg pin", {27'b0, negative_select}, 32'h0000_0010);
    check("gain zero", {26'b0, gain_code_channel_zero}, 32'h0000_0020);
    check("gain one", {26'b0, gain_code_channel_one}, 32'h0000_0011);
    check("bypass", {30'b0, buffer_bypass_pos, buffer_bypass_neg}, 32'h0000_0003);
    rd_chk(sarc_pkg::ADDR_POS, 32'h0000_000d, 1'b0);
    rd_chk(sarc_pkg::ADDR_NEG, 32'h0000_0010, 1'b0);
    rd_chk(sarc_pkg::ADDR_GAIN, 32'h0000_0811, 1'b0);
    rd_chk(sarc_pkg::ADDR_STA, 32'h0000_0000, 1'b0);
    // last conversions ran with the comparator high; the write must not touch it
    rd_chk(sarc_pkg::ADDR_DAT, 32'h0fff_0000, 1'b0);
    wr(sarc_pkg::ADDR_RST, 32'h0000_0001);
    rd_chk(sarc_pkg::ADDR_CTRL, 32'h0000_0a00, 1'b0);
    foreach (raddr[i]) rd_chk(raddr[i], 32'h0000_0000, 1'b0);
    check("power after reset", {31'b0, power_enable}, 32'h0000_0000);
    results();
  end

  // whole run is a few thousand cycles; far beyond that is a hang
  initial begin
    #(25 * 20000);
    fails++;
    results();
  end
endmodule
`default_nettype wire
